//--- logic/rcg_top.sv
/*
  Ranging code clock generator: derives fast and slow code clocks from the
  sampled reference, runs the fast and slow sequences, forms the quarter
  gating waveforms, the data overlay and the composite ranging code.
  Assumes the reference and data pins are synchronous to CLK_I and that the
  reference is well below half the system clock rate.
*/
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
// Functional notes
// - Code is slow bit XOR (fast bit AND quarter gate) XOR data waveform.
// - Data waveform low unless enabled; pulses slow bits 2+16N or 10+16N.
// - Every clock and timing signal comes from the one reference input.
// - Output buffer enable behaves as NOR input, active at logic zero.
// - Fast and slow recursions with stated start states and periods 511, 127.
// - Sequence bit signals are high while that bit sits in the last stage.
// - Inverted reference halved forms fast gate; true reference gated gives fast clock.
// - Inverted reference gated by slow enable gives slow clock, fast rate over 1022.
// - Half-rate square wave resampled by true reference gives fast phase wave.
// - Slow enable interval on only every second fast end-of-period pulse.
// - Nine-stage fast shift register with decoders for bits 255 and 510.
// - Zero detect on first eight fast stages forces recovery from all zeros.
// - Phase shift high loads zero into fast stage two instead of the stage one bit.
// - Shift one fast clock after bit 510 inserts zero state, delays two bits.
// - Bit 510 and 255 decodes delayed one fast clock give 511, 256 pulses.
// - Slow gate falls at end of bit 511 pulse, rises at end of 256 pulse.
// - Half gate toggles at end of 511 pulse; quarter toggles at end of 256.
// - Pulses and slow gating waveforms all come from fast clock registers.
// - Slow enable from 511 pulse, half gate, square wave; coincides with half fall.
// - Fast sequence advances per fast clock; slow sequence per slow clock.
// - Seven-stage slow register with zero detect on first six stages.
`timescale 1ns/1ps
module rcg_top
  import rcg_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // Reference and data inputs
  input  wire logic        REFERENCE_CLOCK_ANALOG_INPUT_I,
  input  wire logic        DATA_I,
  input  wire logic        OUTPUT_ENABLE_N_I,
  // AHB-Lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output wire logic [31:0] HRDATA_O,
  output wire logic        HREADYOUT_O,
  output wire logic        HRESP_O,
  // Clock outputs
  output wire logic        FAST_CODE_CLOCK_O,
  output wire logic        SLOW_CODE_CLOCK_O,
  output wire logic        FAST_CLOCK_GATE_O,
  output wire logic        SLOW_CLOCK_GATE_O,
  // Code and timing outputs
  output wire logic        COMPOSITE_RANGING_CODE_O,
  output wire logic        RANGING_SQUARE_WAVE_OUTPUT_O,
  output wire logic        FAST_BIT_511_O,
  output wire logic        FAST_BIT_256_O,
  output wire logic        QUARTER_GATE_O,
  output wire logic        DATA_SLOT_ONE_PULSE_O,
  output wire logic        DATA_SLOT_ZERO_PULSE_O
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       ref_s;
    logic       fgate;
    logic       fclk;
    logic       sgate;
    logic       sclk;
    logic       sq;
    logic [8:0] fast;
    logic [6:0] slow;
    logic [6:0] sidx;
    logic       h511;
    logic       h256;
    logic       fl;
    logic       fhalf;
    logic       quarter;
    logic       code;
    logic       code_out;
    logic       sq_out;
    logic       shift_pend;
    logic       data_s;
    logic       slot1;
    logic       slot0;
  } rcg_core_t;

  rcg_core_t s_reg;
  rcg_core_t s_next;

  logic        data_en;
  logic        shift_set;
  logic [31:0] status_word;
  logic [31:0] index_word;

  function automatic logic [6:0] rcg_idx_next(input logic [6:0] i);
    return (i == SLOW_IDX_LAST) ? SLOW_IDX_FIRST : 7'(i + SLOW_IDX_STEP);
  endfunction

  function automatic logic rcg_slot(input logic [6:0] i, input logic [3:0] res);
    return i[3:0] == res;
  endfunction

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  rcg_ahb_regs u_regs (
    .CLK_I         (CLK_I),
    .RST_N_I       (RST_N_I),
    .HSEL_I        (HSEL_I),
    .HADDR_I       (HADDR_I),
    .HTRANS_I      (HTRANS_I),
    .HWRITE_I      (HWRITE_I),
    .HSIZE_I       (HSIZE_I),
    .HWDATA_I      (HWDATA_I),
    .HREADY_I      (HREADY_I),
    .HRDATA_O      (HRDATA_O),
    .HREADYOUT_O   (HREADYOUT_O),
    .HRESP_O       (HRESP_O),
    .SHIFT_PEND_I  (s_reg.shift_pend),
    .STATUS_WORD_I (status_word),
    .INDEX_WORD_I  (index_word),
    .DATA_EN_O     (data_en),
    .SHIFT_SET_O   (shift_set)
  );

  always_comb
  begin
    status_word                 = WORD_ZERO;
    status_word[ST_FAST_LSB +: FAST_LEN] = s_reg.fast;
    status_word[ST_SLOW_LSB +: SLOW_LEN] = s_reg.slow;
    status_word[ST_FL_BIT]      = s_reg.fl;
    status_word[ST_HALF_BIT]    = s_reg.fhalf;
    status_word[ST_QUARTER_BIT] = s_reg.quarter;
    index_word                  = WORD_ZERO;
    index_word[SLOW_LEN-1:0]    = s_reg.sidx;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic ref_rise;
    logic inv_rise;
    logic fast_tick;
    logic dec_a;
    logic dec_b;
    logic end511;
    logic end256;
    logic slow_tick;
    logic shift_apply;
    logic dprime;
    logic [6:0] idx_n;
    ref_rise    = 1'b0;
    inv_rise    = 1'b0;
    fast_tick   = 1'b0;
    dec_a       = 1'b0;
    dec_b       = 1'b0;
    end511      = 1'b0;
    end256      = 1'b0;
    slow_tick   = 1'b0;
    shift_apply = 1'b0;
    dprime      = 1'b0;
    idx_n       = s_reg.sidx;
    s_next      = s_reg;

    // Edges of the sampled reference stand in for its true and inverted phases
    ref_rise     = REFERENCE_CLOCK_ANALOG_INPUT_I & ~s_reg.ref_s;
    inv_rise     = ~REFERENCE_CLOCK_ANALOG_INPUT_I & s_reg.ref_s;
    s_next.ref_s = REFERENCE_CLOCK_ANALOG_INPUT_I;

    // Fast clock: inverted reference halved, true reference gated
    if (inv_rise)
      s_next.fgate = ~s_reg.fgate;
    fast_tick   = ref_rise & s_reg.fgate;
    s_next.fclk = REFERENCE_CLOCK_ANALOG_INPUT_I & s_next.fgate;
    if (ref_rise)
      s_next.sq = s_reg.fgate;

    // Fast generator decoders
    dec_a = (s_reg.fast == FAST_STATE_A);
    dec_b = (s_reg.fast == FAST_STATE_B);

    // Ends of the retimed pulses mark the gate transitions
    end511 = fast_tick & s_reg.h511 & ~dec_b;
    end256 = fast_tick & s_reg.h256 & ~dec_a;

    // Only the 511 pulse that drops the half gate opens a slow clock
    slow_tick = end511 & s_reg.fhalf;

    // Shift held for the one fast clock right after bit 510
    shift_apply = fast_tick & s_reg.h511 & s_reg.shift_pend;

    if (fast_tick)
    begin
      // Zero into stage two while shifting; eight-stage zero detect restores
      s_next.fast = rcg_fast_step(s_reg.fast, shift_apply);
      s_next.h511 = dec_b;
      s_next.h256 = dec_a;
    end

    if (end511)
    begin
      s_next.fl    = 1'b0;
      s_next.fhalf = ~s_reg.fhalf;
    end
    if (end256)
    begin
      s_next.fl      = 1'b1;
      s_next.quarter = ~s_reg.quarter;
    end

    // Software request wins over the clear in the same cycle
    if (shift_apply)
      s_next.shift_pend = 1'b0;
    if (shift_set)
      s_next.shift_pend = 1'b1;

    // Slow clock gate spans the inverted half of the closing fast bit
    // Uses the new gate value so only one reference-low half falls inside it
    s_next.sgate = s_reg.h511 & s_reg.fhalf & ~s_next.fgate;
    s_next.sclk  = ~REFERENCE_CLOCK_ANALOG_INPUT_I & s_next.sgate;

    if (slow_tick)
    begin
      idx_n        = rcg_idx_next(s_reg.sidx);
      s_next.slow  = rcg_slow_step(s_reg.slow);
      s_next.sidx  = idx_n;
      s_next.slot1 = rcg_slot(idx_n, SLOT_ONE_RES);
      s_next.slot0 = rcg_slot(idx_n, SLOT_ZERO_RES);
      // Data only moves once per slow bit; a faster source is undersampled
      s_next.data_s = DATA_I;
    end

    // Data waveform
    dprime = data_en & (s_reg.data_s ? s_reg.slot1 : s_reg.slot0);

    // Composite code, retimed on the fast clock
    if (fast_tick)
      s_next.code = s_reg.slow[SLOW_LEN-1] ^ (s_reg.fast[FAST_LEN-1] & s_reg.quarter)
                    ^ dprime;

    // Both outputs share one resampling edge, so their phase stays locked
    if (inv_rise)
    begin
      s_next.code_out = ~(~s_reg.code | OUTPUT_ENABLE_N_I);
      s_next.sq_out   = ~(~s_reg.sq | OUTPUT_ENABLE_N_I);
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset only sets a known start; the zero detectors recover without it
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      s_reg            <= '0;
      s_reg.fast       <= FAST_INIT;
      s_reg.slow       <= SLOW_INIT;
      s_reg.sidx       <= SLOW_IDX_FIRST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign FAST_CODE_CLOCK_O            = s_reg.fclk;
  assign SLOW_CODE_CLOCK_O            = s_reg.sclk;
  assign FAST_CLOCK_GATE_O            = s_reg.fgate;
  assign SLOW_CLOCK_GATE_O            = s_reg.sgate;
  assign COMPOSITE_RANGING_CODE_O     = s_reg.code_out;
  assign RANGING_SQUARE_WAVE_OUTPUT_O = s_reg.sq_out;
  assign FAST_BIT_511_O               = s_reg.h511;
  assign FAST_BIT_256_O               = s_reg.h256;
  assign QUARTER_GATE_O               = s_reg.quarter;
  assign DATA_SLOT_ONE_PULSE_O        = s_reg.slot1;
  assign DATA_SLOT_ZERO_PULSE_O       = s_reg.slot0;

endmodule

//--- logic/rcg_pkg.sv
/*
  Constants, register map and sequence step functions for the ranging code
  clock generator. Assumes a single system clock that samples the reference.
*/
package rcg_pkg;

  // ----------------------------------------------------------------------
  // Sequence generator geometry
  // ----------------------------------------------------------------------
  localparam int unsigned FAST_LEN       = 9;
  localparam int unsigned SLOW_LEN       = 7;
  // Stage 2 holds bit 8 (fast) or bit 6 (slow) when bit 1 sits in the last stage
  localparam logic [8:0]  FAST_INIT      = 9'h002;
  localparam logic [6:0]  SLOW_INIT      = 7'h02;
  localparam int unsigned FAST_BIT_A     = 255;
  localparam int unsigned FAST_BIT_B     = 510;
  localparam int unsigned FIRST_BIT      = 1;
  localparam logic [6:0]  SLOW_IDX_FIRST = 7'h01;
  localparam logic [6:0]  SLOW_IDX_LAST  = 7'h7F;
  localparam logic [6:0]  SLOW_IDX_STEP  = 7'h01;
  localparam logic [3:0]  SLOT_ONE_RES   = 4'h2;
  localparam logic [3:0]  SLOT_ZERO_RES  = 4'hA;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W           = 4;
  localparam logic [3:0]  OFS_CTRL         = 4'h0;
  localparam logic [3:0]  OFS_STATUS       = 4'h4;
  localparam logic [3:0]  OFS_INDEX        = 4'h8;
  localparam int unsigned CTRL_DATA_EN_BIT = 0;
  localparam int unsigned CTRL_SHIFT_BIT   = 1;
  localparam int unsigned ST_FAST_LSB      = 0;
  localparam int unsigned ST_SLOW_LSB      = 16;
  localparam int unsigned ST_FL_BIT        = 24;
  localparam int unsigned ST_HALF_BIT      = 25;
  localparam int unsigned ST_QUARTER_BIT   = 26;
  localparam logic        CTRL_DATA_EN_RST = 1'b0;
  localparam logic [31:0] WORD_ZERO        = 32'h0000_0000;
  localparam logic        HRESP_OKAY       = 1'b0;

  // ----------------------------------------------------------------------
  // Step functions
  // ----------------------------------------------------------------------
  // Index 0 is the first stage; the top index is the output stage
  function automatic logic [8:0] rcg_fast_step(input logic [8:0] s, input logic shift);
    logic [8:0] n;
    n      = {s[7:0], 1'b0};
    n[0]   = (s[8] ^ s[3]) | (s[7:0] == 8'h00);
    n[1]   = shift ? 1'b0 : s[0];
    return n;
  endfunction

  function automatic logic [6:0] rcg_slow_step(input logic [6:0] s);
    logic [6:0] n;
    n      = {s[5:0], 1'b0};
    n[0]   = (s[6] ^ s[5]) | (s[5:0] == 6'h00);
    return n;
  endfunction

  function automatic logic [8:0] rcg_fast_at(input int unsigned bit_no);
    logic [8:0] s;
    s = FAST_INIT;
    for (int unsigned i = FIRST_BIT; i < bit_no; i++)
      s = rcg_fast_step(s, 1'b0);
    return s;
  endfunction

  localparam logic [8:0] FAST_STATE_A = rcg_fast_at(FAST_BIT_A);
  localparam logic [8:0] FAST_STATE_B = rcg_fast_at(FAST_BIT_B);

endpackage

//--- logic/rcg_ahb_regs.sv
/*
  AHB-Lite slave holding the control register and returning status words.
  Assumes one master, single word transfers, and status words from the core.
*/
`timescale 1ns/1ps
module rcg_ahb_regs
  import rcg_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  // AHB-Lite slave
  input  wire logic              HSEL_I,
  input  wire logic [31:0]       HADDR_I,
  input  wire logic [1:0]        HTRANS_I,
  input  wire logic              HWRITE_I,
  input  wire logic [2:0]        HSIZE_I,
  input  wire logic [31:0]       HWDATA_I,
  input  wire logic              HREADY_I,
  output wire logic [31:0]       HRDATA_O,
  output wire logic              HREADYOUT_O,
  output wire logic              HRESP_O,
  // Core side
  input  wire logic              SHIFT_PEND_I,
  input  wire logic [31:0]       STATUS_WORD_I,
  input  wire logic [31:0]       INDEX_WORD_I,
  output wire logic              DATA_EN_O,
  output wire logic              SHIFT_SET_O
);

  typedef struct packed {
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       rdata;
    logic              data_en;
    logic              shift_set;
  } rcg_bus_t;

  rcg_bus_t s_reg;
  rcg_bus_t s_next;

  function automatic logic [31:0] rcg_read_word(input logic [ADDR_W-1:0] a,
                                                input logic de, input logic sp,
                                                input logic [31:0] st,
                                                input logic [31:0] ix);
    logic [31:0] w;
    w = WORD_ZERO;
    case (a)
      OFS_CTRL:
      begin
        w[CTRL_DATA_EN_BIT] = de;
        w[CTRL_SHIFT_BIT]   = sp;
      end
      OFS_STATUS: w = st;
      OFS_INDEX:  w = ix;
      default:    w = WORD_ZERO;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // HSIZE is not checked: every access is treated as a whole word
  always_comb
  begin
    logic acc;
    acc    = HSEL_I & HREADY_I & HTRANS_I[1];
    s_next = s_reg;
    s_next.shift_set = 1'b0;
    s_next.wr_pend   = acc & HWRITE_I;
    if (acc)
      s_next.wr_addr = HADDR_I[ADDR_W-1:0];
    if (acc && !HWRITE_I)
      s_next.rdata = rcg_read_word(HADDR_I[ADDR_W-1:0], s_reg.data_en, SHIFT_PEND_I,
                                   STATUS_WORD_I, INDEX_WORD_I);
    if (s_reg.wr_pend && s_reg.wr_addr == OFS_CTRL)
    begin
      s_next.data_en   = HWDATA_I[CTRL_DATA_EN_BIT];
      s_next.shift_set = HWDATA_I[CTRL_SHIFT_BIT];
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      s_reg <= '{wr_pend: 1'b0, wr_addr: '0, rdata: WORD_ZERO,
                 data_en: CTRL_DATA_EN_RST, shift_set: 1'b0};
    else
      s_reg <= s_next;
  end

  assign HRDATA_O    = s_reg.rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = HRESP_OKAY;
  assign DATA_EN_O   = s_reg.data_en;
  assign SHIFT_SET_O = s_reg.shift_set;

endmodule

//--- verif/rcg_ref_src.sv
/*
  Far-side model: the reference source and the slow serial data source.
  Assumes the bench clock samples it; the reference stands low while stopped.
*/
`timescale 1ns/1ps
module rcg_ref_src
#(
  parameter int HALF = 2
)
(
  // Control
  input  wire logic clk_i,
  input  wire logic run_i,
  input  wire logic data_lvl_i,
  // Source outputs
  output logic      ref_o,
  output logic      data_o
);
  int cnt = 0;
  initial ref_o = 1'b0;
  // Far faster than nominal so that slow bits pass in a short run
  always @(posedge clk_i)
  begin
    if (!run_i)
    begin
      ref_o <= 1'b0;
      cnt   <= 0;
    end
    else if (cnt == HALF - 1)
    begin
      ref_o <= !ref_o;
      cnt   <= 0;
    end
    else
      cnt <= cnt + 1;
  end
  // Data level held across many slow bits
  assign data_o = data_lvl_i;
endmodule

//--- verif/rcg_top_asserts.sv
/*
  Concurrent checks on the clock, pulse and gate outputs of rcg_top.
  Assumes it is bound to rcg_top and sees its ports by name.
*/
`timescale 1ns/1ps
module rcg_top_asserts
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Watched outputs
  input wire logic FAST_CODE_CLOCK_O,
  input wire logic SLOW_CODE_CLOCK_O,
  input wire logic SLOW_CLOCK_GATE_O,
  input wire logic FAST_CLOCK_GATE_O,
  input wire logic COMPOSITE_RANGING_CODE_O,
  input wire logic RANGING_SQUARE_WAVE_OUTPUT_O,
  input wire logic FAST_BIT_511_O,
  input wire logic FAST_BIT_256_O,
  input wire logic QUARTER_GATE_O,
  input wire logic DATA_SLOT_ONE_PULSE_O,
  input wire logic DATA_SLOT_ZERO_PULSE_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  fclk_gate_a: assert property (FAST_CODE_CLOCK_O |-> FAST_CLOCK_GATE_O || $past(FAST_CLOCK_GATE_O))
    else $error("fast clock without gate");
  clk_excl_a: assert property (!(FAST_CODE_CLOCK_O && SLOW_CODE_CLOCK_O))
    else $error("fast and slow clocks overlap");
  slow_in511_a: assert property (SLOW_CODE_CLOCK_O |-> FAST_BIT_511_O)
    else $error("slow clock outside 511 pulse");
  sgate_clk_a: assert property (SLOW_CODE_CLOCK_O |-> SLOW_CLOCK_GATE_O)
    else $error("slow clock outside its gate");
  slow_once_a: assert property ($fell(SLOW_CODE_CLOCK_O) |-> !SLOW_CODE_CLOCK_O [*8])
    else $error("second slow clock pulse in one slow bit");
  slow_tick_a: assert property ($rose(SLOW_CODE_CLOCK_O) |-> ##[1:40] $fell(FAST_BIT_511_O))
    else $error("slow clock not followed by tick");
  pulse_excl_a: assert property (!(FAST_BIT_511_O && FAST_BIT_256_O))
    else $error("511 and 256 pulses overlap");
  quarter_tog_a: assert property ($changed(QUARTER_GATE_O) == $fell(FAST_BIT_256_O))
    else $error("quarter gate toggle misplaced");
  slot_excl_a: assert property (!(DATA_SLOT_ONE_PULSE_O && DATA_SLOT_ZERO_PULSE_O))
    else $error("both slot pulses high");
  slot_tick_a: assert property ($changed(DATA_SLOT_ONE_PULSE_O) |-> $fell(FAST_BIT_511_O))
    else $error("slot pulse off slow tick");
  code_resamp_a: assert property ($changed(COMPOSITE_RANGING_CODE_O) |-> $changed(FAST_CLOCK_GATE_O))
    else $error("code changed off resample");
  sqw_resamp_a: assert property ($changed(RANGING_SQUARE_WAVE_OUTPUT_O) |-> $changed(FAST_CLOCK_GATE_O))
    else $error("square wave changed off resample");
endmodule

bind rcg_top rcg_top_asserts chk_u (.*);

//--- verif/tb_rcg_top.sv
/*
  Self-checking bench for rcg_top: register rows, fast period walk, phase
  shift, slow ticks and slot pulses. Assumes a fast reference from the model.
*/
`timescale 1ns/1ps
module tb_rcg_top
  import rcg_pkg::*;
;
  logic        clk, rst_n, ref_run, data_lvl, oe_n, hsel, hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, rd;
  wire logic [31:0] hrdata;
  wire logic   hreadyout, fclk, sclk, fgate, code, sqw, b511, b256, qgate, slot1, slot0;
  wire logic   ref_lvl, data_w;
  int          n_errors, cmp_count, cyc, ticks, slow_n, n511, gap511, t511, tslow, sgap, s1_at;
  logic        fc_q, sc_q, b5_q, d1_q;
  logic        hb [1:520];
  logic        lb [1:140];
  logic [68:0] rows [0:10] = '{
    {1'b0, OFS_STATUS, WORD_ZERO, 32'h0002_0002},
    {1'b0, OFS_INDEX, WORD_ZERO, 32'h0000_0001},
    {1'b0, OFS_CTRL, WORD_ZERO, WORD_ZERO},
    {1'b1, 4'hC, 32'hFFFF_FFFF, WORD_ZERO},
    {1'b0, 4'hC, WORD_ZERO, WORD_ZERO},
    {1'b1, OFS_STATUS, 32'hFFFF_FFFF, WORD_ZERO},
    {1'b0, OFS_STATUS, WORD_ZERO, 32'h0002_0002},
    {1'b1, OFS_CTRL, 32'h0000_0001, WORD_ZERO},
    {1'b0, OFS_CTRL, WORD_ZERO, 32'h0000_0001},
    {1'b1, OFS_CTRL, WORD_ZERO, WORD_ZERO},
    {1'b0, OFS_CTRL, WORD_ZERO, WORD_ZERO}
  };

  rcg_ref_src src_u (.clk_i(clk), .run_i(ref_run), .data_lvl_i(data_lvl), .ref_o(ref_lvl),
    .data_o(data_w));
  rcg_top dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .REFERENCE_CLOCK_ANALOG_INPUT_I(ref_lvl),
    .DATA_I(data_w), .OUTPUT_ENABLE_N_I(oe_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(),
    .FAST_CODE_CLOCK_O(fclk), .SLOW_CODE_CLOCK_O(sclk), .FAST_CLOCK_GATE_O(fgate),
    .SLOW_CLOCK_GATE_O(), .COMPOSITE_RANGING_CODE_O(code),
    .RANGING_SQUARE_WAVE_OUTPUT_O(sqw), .FAST_BIT_511_O(b511), .FAST_BIT_256_O(b256),
    .QUARTER_GATE_O(qgate), .DATA_SLOT_ONE_PULSE_O(slot1), .DATA_SLOT_ZERO_PULSE_O(slot0));

  // ------------
  // Helpers
  // ------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [8:0] fexp(input int k);
    logic [8:0] e;
    for (int j = 0; j < 9; j++)
      e[8-j] = hb[k+j];
    return e;
  endfunction

  function automatic logic [6:0] lexp(input int m);
    logic [6:0] e;
    for (int j = 0; j < 7; j++)
      e[6-j] = lb[m+j];
    return e;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Called just after a rising edge; read data lands in rd
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    rd = hrdata;
  endtask

  // Sampled on the falling edge so that settled outputs are counted
  always @(negedge clk)
  begin
    cyc++;
    if (fclk && !fc_q)
      ticks++;
    if (sclk && !sc_q)
    begin
      sgap = ticks - tslow;
      tslow = ticks;
      slow_n++;
    end
    if (b511 && !b5_q)
    begin
      gap511 = ticks - t511;
      t511 = ticks;
      n511++;
    end
    if (slot1 && !d1_q)
      s1_at = slow_n;
    {fc_q, sc_q, b5_q, d1_q} = {fclk, sclk, b511, slot1};
    if (cyc == 90000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  // ------------
  // Main sequence
  // ------------
  initial
  begin
    logic prev;
    for (int k = 1; k <= 520; k++)
      hb[k] = (k <= 9) ? (k == 8) : hb[k-9] ^ hb[k-4];
    for (int m = 1; m <= 140; m++)
      lb[m] = (m <= 7) ? (m == 6) : lb[m-7] ^ lb[m-6];
    {rst_n, ref_run, data_lvl, oe_n, hsel, hwrite, htrans} = 8'h04 << 1;
    {hsize, haddr, hwdata} = {3'h2, WORD_ZERO, WORD_ZERO};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 11; i++)
    begin
      ahb(rows[i][68], 32'(rows[i][67:64]), rows[i][63:32]);
      if (!rows[i][68])
        check(rd, rows[i][31:0]);
    end
    ref_run <= 1'b1;
    @(negedge b511);
    for (int k = 1; k <= 511; k++)
    begin
      @(posedge clk);
      ahb(1'b0, 32'(OFS_STATUS), WORD_ZERO);
      check(32'(rd[8:0]), 32'(fexp(k)));
      check(32'({b256, b511}), 32'({k == 256, k == 511}));
      check({qgate, code}, {k < 257, hb[k == 1 ? 511 : k - 1] & (k < 258)});
      @(posedge fclk);
    end
    @(posedge clk);
    ahb(1'b1, 32'(OFS_CTRL), 32'h0000_0003);
    @(posedge clk);
    ahb(1'b0, 32'(OFS_CTRL), WORD_ZERO);
    check(rd, 32'h0000_0003);
    repeat (2) @(n511);
    check(gap511, 513);
    @(n511);
    check(gap511, 511);
    @(posedge clk);
    ahb(1'b0, 32'(OFS_CTRL), WORD_ZERO);
    check(rd, 32'h0000_0001);
    @(posedge slot0);
    @(posedge clk);
    ahb(1'b0, 32'(OFS_INDEX), WORD_ZERO);
    check(rd, 32'h0000_000A);
    ahb(1'b0, 32'(OFS_STATUS), WORD_ZERO);
    check(32'(rd[22:16]), 32'(lexp(10)));
    check(s1_at, 1);
    check(slow_n, 9);
    check(sgap, 1022);
    @(posedge fclk);
    @(negedge fgate);
    @(negedge clk);
    check(code, !lb[10]);
    @(posedge clk);
    oe_n <= 1'b1;
    repeat (2) @(fgate);
    @(negedge clk);
    check(32'({code, sqw}), WORD_ZERO);
    @(posedge clk);
    oe_n <= 1'b0;
    repeat (2) @(fgate);
    @(negedge clk);
    prev = sqw;
    @(fgate);
    @(negedge clk);
    check(32'(sqw), 32'(!prev));
    @(posedge clk);
    ref_run <= 1'b0;
    rst_n   <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'({fclk, b511, qgate, slot0}), WORD_ZERO);
    rst_n <= 1'b1;
    @(posedge clk);
    ahb(1'b0, 32'(OFS_STATUS), WORD_ZERO);
    check(rd, 32'h0002_0002);
    print_verdict();
  end
endmodule
